// >>> hw/beam_eval.sv
// How it works
// RULE1: lockout single-flashes status red; zones and reset indicator are off.
// RULE2: emitter normal mode shows emitter status steady green.
// RULE3: emitter test input open enters test mode; emitter status flashes green.
// RULE4: latch mode turns safety outputs on only after all clear plus reset.
// RULE5: latched and clear: status red, reset double-flash yellow, zones green; the code flashes reset once every four flash phases.
// RULE6: run: status green (flashing with reduced resolution), reset yellow, zones green.
// RULE7: blocked: status red, reset yellow, blocked zones red, count displayed.
// RULE8: sync beam blocked: zone one red, all other zones off.
// RULE9: test input open: display beams minus one, zones red; ten beams keep zone one green.
// RULE10: power-up flashes every indicator, then displays the scan code.
// RULE11: first channel misaligned: status and zone one red, code shown, zones 2-8 off.
// RULE12: as beams clear, zones turn green and displayed count drops.
// RULE13: lockout shown by flashing red status and held until cleared.
// RULE14: reduced resolution tolerates two adjacent blocked beams except the sync beam.
// RULE15: blanked regions need at least one unblanked beam between them; the code does not check this.
// RULE16: the sync beam can never be blanked.
// RULE17: after teaching, outputs stay on only while all blanked beams stay blocked.
// RULE18: reset accepted only as closure of a quarter to two seconds, then release.
//
// Local design decisions: register access over AHB-Lite and the placing of the registers.
module beam_eval
   import beam_eval_pkg::*;
#(
   parameter int     NBEAMS       = 16,
   parameter int     NZONES       = 8,
   parameter longint SELFTEST_N   = SELFTEST_CYC,
   parameter longint FLASH_N      = FLASH_CYC,
   parameter longint RESET_MIN_N  = RESET_MIN_CYC,
   parameter longint RESET_MAX_N  = RESET_MAX_CYC,
   parameter logic [3:0] SCAN_CODE = 4'h1
) (
   input  wire logic                 clk_sys,
   input  wire logic                 resetn,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hsel,
   input  wire logic                 hready,
   output logic      [31:0]          hrdata,
   output logic                      hreadyout,
   output logic                      hresp,
   input  wire logic [NBEAMS-1:0]    beam_blocked,
   input  wire logic                 reset_switch,
   input  wire logic                 test_input_open,
   output logic                      safety_switching_output,
   output beam_eval_pkg::led_t       status_led,
   output beam_eval_pkg::led_t       emitter_status_led,
   output logic                      reset_led,
   output beam_eval_pkg::led_t       zone_led [NZONES],
   output logic      [11:0]          display,
   output logic                      irq
);
   import beam_eval_pkg::*;

   localparam int BPZ = (NBEAMS + NZONES - 1) / NZONES;

   // =====================================================
   // pin synchronisers
   // =====================================================
   logic [NBEAMS-1:0] beam_s1_q, beam_s2_q;
   logic              rsw_s1_q, rsw_s2_q, tst_s1_q, tst_s2_q;
   // first stage feeds only the second stage
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         beam_s1_q <= '0;
         beam_s2_q <= '0;
         rsw_s1_q  <= 1'b0;
         rsw_s2_q  <= 1'b0;
         tst_s1_q  <= 1'b0;
         tst_s2_q  <= 1'b0;
      end else begin
         beam_s1_q <= beam_blocked;
         beam_s2_q <= beam_s1_q;
         rsw_s1_q  <= reset_switch;
         rsw_s2_q  <= rsw_s1_q;
         tst_s1_q  <= test_input_open;
         tst_s2_q  <= tst_s1_q;
      end
   end

   // =====================================================
   // register file and AHB-Lite slave
   // =====================================================
   logic [3:0]        ctrl_q;
   logic [NBEAMS-1:0] blank_q;
   logic [4:0]        irq_stat_q, irq_mask_q, irq_ev;
   logic              wr_pend_q, rd_pend_q;
   logic [7:0]        addr_q;
   logic              lock_clr;
   logic              blank_bad;

   wire take = hsel & hready & htrans[1];
   assign hreadyout = 1'b1;    // zero wait state
   assign hresp     = 1'b0;

   // address phase capture
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q    <= 8'h00;
      end else begin
         wr_pend_q <= take & hwrite;
         rd_pend_q <= take & ~hwrite;
         if (take) addr_q <= haddr[7:0];
      end
   end

   // sync beam never blankable; spacing between separate blanked regions is not checked
   assign blank_bad = hwdata[0];                              // RULE16

   // control and blanking writes; teach captures on the write that clears teach mode
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctrl_q  <= CTRL_RESET_VAL[3:0];
         blank_q <= '0;
      end else if (wr_pend_q && addr_q == CTRL_OFFSET) begin
         ctrl_q  <= hwdata[3:0];
         if (ctrl_q[CTRL_TEACH_BIT] && !hwdata[CTRL_TEACH_BIT])
            blank_q <= beam_s2_q & ~NBEAMS'(1);            // RULE16
      end else if (wr_pend_q && addr_q == BLANK_OFFSET && !blank_bad) begin
         blank_q <= hwdata[NBEAMS-1:0];                     // RULE15
      end
   end
   assign lock_clr = wr_pend_q && addr_q == CTRL_OFFSET && hwdata[CTRL_LOCKCLR_BIT];

   // sticky status, set beats write-one-to-clear
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         irq_stat_q <= '0;
         irq_mask_q <= IRQ_MASK_RESET;
      end else begin
         if (wr_pend_q && addr_q == IRQ_MASK_OFFSET) irq_mask_q <= hwdata[4:0];
         if (wr_pend_q && addr_q == IRQ_STAT_OFFSET)
            irq_stat_q <= (irq_stat_q & ~hwdata[4:0]) | irq_ev;
         else
            irq_stat_q <= irq_stat_q | irq_ev;
      end
   end
   assign irq = |(irq_stat_q & irq_mask_q);

   // =====================================================
   // timers: flash phase, power-up self-test, reset switch
   // =====================================================
   logic [31:0] flash_cnt_q, st_cnt_q, rsw_cnt_q;
   logic [1:0]  flash_ph_q;
   logic        selftest_q, rsw_prev_q, valid_reset;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         flash_cnt_q <= '0;
         flash_ph_q  <= 2'd0;
      end else if (flash_cnt_q == 32'(FLASH_N - 1)) begin
         flash_cnt_q <= '0;
         flash_ph_q  <= flash_ph_q + 2'd1;
      end else begin
         flash_cnt_q <= flash_cnt_q + 32'd1;
      end
   end
   wire blink  = flash_ph_q[0];
   wire dblink = (flash_ph_q != 2'd3) & blink;   // single flash every four phases

   // self-test runs once after reset release
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_cnt_q   <= '0;
         selftest_q <= 1'b1;
      end else if (selftest_q) begin
         st_cnt_q <= st_cnt_q + 32'd1;
         if (st_cnt_q == 32'(SELFTEST_N - 1)) selftest_q <= 1'b0;  // RULE10
      end
   end

   // closure length measured; too short or too long is ignored
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rsw_cnt_q  <= '0;
         rsw_prev_q <= 1'b0;
      end else begin
         rsw_prev_q <= rsw_s2_q;
         if (!rsw_s2_q) rsw_cnt_q <= '0;
         else if (rsw_cnt_q != 32'hFFFF_FFFF) rsw_cnt_q <= rsw_cnt_q + 32'd1;
      end
   end
   assign valid_reset = rsw_prev_q & ~rsw_s2_q &
                        rsw_cnt_q >= 32'(RESET_MIN_N) & rsw_cnt_q <= 32'(RESET_MAX_N); // RULE18

   // =====================================================
   // beam evaluation
   // =====================================================
   logic [NBEAMS-1:0] eff_blk;
   logic              trip, blank_lost, sync_blk;
   logic [7:0]        nblk;

   // reduced resolution: isolated pairs of adjacent blocked beams pass
   function automatic logic [NBEAMS-1:0] rr_filter(input logic [NBEAMS-1:0] b);
      logic [NBEAMS-1:0] r;
      r = b;
      for (int i = 1; i + 1 < NBEAMS; i++) begin
         if (b[i] && b[i+1] && !b[i-1] && (i + 2 >= NBEAMS || !b[i+2])) begin
            r[i]   = 1'b0;                                   // RULE14
            r[i+1] = 1'b0;
         end
      end
      for (int i = 1; i < NBEAMS; i++)
         if (b[i] && !b[i-1] && (i + 1 >= NBEAMS || !b[i+1])) r[i] = 1'b0;
      rr_filter = r;
   endfunction : rr_filter

   function automatic logic [7:0] popcount(input logic [NBEAMS-1:0] b);
      popcount = 8'h00;
      for (int i = 0; i < NBEAMS; i++) popcount = popcount + 8'(b[i]);
   endfunction : popcount

   always_comb begin
      eff_blk = beam_s2_q & ~blank_q;
      if (ctrl_q[CTRL_RR_BIT]) eff_blk = rr_filter(eff_blk);
      eff_blk[0] = beam_s2_q[0];                             // RULE14
   end
   assign sync_blk   = beam_s2_q[0];
   assign blank_lost = |(blank_q & ~beam_s2_q);              // RULE17
   assign trip       = (|eff_blk) | tst_s2_q;
   assign nblk       = popcount(beam_s2_q & ~blank_q);

   // =====================================================
   // run / latch / lockout state
   // =====================================================
   typedef enum {ST_SELFTEST, ST_RUN, ST_STOP, ST_LATCH, ST_LOCKOUT} state_t;
   state_t st_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_q <= ST_SELFTEST;
      end else begin
         case (st_q)
            ST_SELFTEST: if (!selftest_q) st_q <= ST_STOP;
            ST_RUN:      if (blank_lost) st_q <= ST_LOCKOUT;          // RULE17
                         else if (trip) st_q <= ST_STOP;
            ST_STOP:     if (blank_lost && !ctrl_q[CTRL_TEACH_BIT]) st_q <= ST_LOCKOUT;
                         else if (!trip && !ctrl_q[CTRL_TEACH_BIT])
                            st_q <= ctrl_q[CTRL_LATCH_BIT] ? ST_LATCH : ST_RUN;
            ST_LATCH:    if (trip) st_q <= ST_STOP;
                         else if (valid_reset) st_q <= ST_RUN;       // RULE4
            ST_LOCKOUT:  if (lock_clr || valid_reset) st_q <= ST_STOP; // RULE13
            default:     st_q <= ST_STOP;
         endcase
      end
   end

   assign irq_ev[IRQ_TRIP_BIT]  = st_q == ST_RUN && (trip || blank_lost);
   assign irq_ev[IRQ_CLEAR_BIT] = st_q != ST_RUN && st_q != ST_LOCKOUT && !trip;
   assign irq_ev[IRQ_LOCK_BIT]  = st_q == ST_RUN && blank_lost;
   assign irq_ev[IRQ_RESET_BIT] = valid_reset;
   assign irq_ev[IRQ_SYNC_BIT]  = sync_blk;

   // =====================================================
   // outputs: safety output, indicators, display
   // =====================================================
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         safety_switching_output <= 1'b0;
      end else begin
         safety_switching_output <= st_q == ST_RUN && !trip && !blank_lost;  // RULE4
      end
   end

   // emitter side indicator
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         emitter_status_led <= LED_OFF;
      end else if (selftest_q) begin
         emitter_status_led <= blink ? LED_GREEN : LED_RED;    // RULE10
      end else if (tst_s2_q) begin
         emitter_status_led <= blink ? LED_GREEN : LED_OFF;    // RULE3
      end else begin
         emitter_status_led <= LED_GREEN;                      // RULE2
      end
   end

   // receiver status, reset and display
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         status_led <= LED_OFF;
         reset_led  <= 1'b0;
         display    <= 12'h000;
      end else begin
         status_led <= LED_RED;
         reset_led  <= 1'b1;
         display    <= {4'h0, nblk};                           // RULE7 RULE12
         case (st_q)
            ST_SELFTEST: begin
               status_led <= blink ? LED_GREEN : LED_RED;      // RULE10
               reset_led  <= blink;
               display    <= 12'hFFF;
            end
            ST_LOCKOUT: begin
               status_led <= blink ? LED_RED : LED_OFF;        // RULE1 RULE13
               reset_led  <= 1'b0;
            end
            ST_LATCH: reset_led <= dblink;                     // RULE5
            ST_RUN: begin
               status_led <= (ctrl_q[CTRL_RR_BIT] && blink) ? LED_OFF : LED_GREEN; // RULE6
               display    <= CODE_SCAN_BASE | {8'h00, SCAN_CODE};
            end
            default: ;
         endcase
         if (st_q != ST_SELFTEST && st_q != ST_LOCKOUT) begin
            if (tst_s2_q) display <= 12'(NBEAMS - 1);            // RULE9
            else if (sync_blk) display <= CODE_MISALIGN;       // RULE11
         end
      end
   end

   // zone indicators
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         for (int z = 0; z < NZONES; z++) zone_led[z] <= LED_OFF;
      end else begin
         for (int z = 0; z < NZONES; z++) begin
            logic zb;
            zb = 1'b0;
            for (int k = 0; k < BPZ; k++)
               if (z * BPZ + k < NBEAMS) zb = zb | (beam_s2_q[z*BPZ+k] & ~blank_q[z*BPZ+k]);
            if (st_q == ST_SELFTEST) zone_led[z] <= blink ? LED_RED : LED_GREEN; // RULE10
            else if (st_q == ST_LOCKOUT) zone_led[z] <= LED_OFF;   // RULE1
            else if (tst_s2_q)
               zone_led[z] <= (z == 0 && NBEAMS == 10) ? LED_GREEN : LED_RED; // RULE9
            else if (sync_blk) zone_led[z] <= (z == 0) ? LED_RED : LED_OFF;  // RULE8 RULE11
            else zone_led[z] <= zb ? LED_RED : LED_GREEN;          // RULE7 RULE12
         end
      end
   end

   // read mux; unmapped reads return zero
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         hrdata <= 32'h0000_0000;
      end else if (take && !hwrite) begin
         case (haddr[7:0])
            CTRL_OFFSET:     hrdata <= {28'h0, ctrl_q};
            STATUS_OFFSET:   hrdata <= {24'h0, 1'b0, blank_lost, safety_switching_output, 1'b0, 4'(st_q)};
            BLANK_OFFSET:    hrdata <= 32'(blank_q);
            IRQ_STAT_OFFSET: hrdata <= {27'h0, irq_stat_q};
            IRQ_MASK_OFFSET: hrdata <= {27'h0, irq_mask_q};
            DISPLAY_OFFSET:  hrdata <= {20'h0, display};
            BEAMS_OFFSET:    hrdata <= 32'(beam_s2_q);
            default:         hrdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule : beam_eval

// >>> hw/beam_eval_pkg.sv
package beam_eval_pkg;
   // =====================================================
   // register map (byte addresses)
   // =====================================================
   localparam logic [7:0]  CTRL_OFFSET      = 8'h00;
   localparam logic [7:0]  STATUS_OFFSET    = 8'h04;
   localparam logic [7:0]  BLANK_OFFSET     = 8'h08;
   localparam logic [7:0]  IRQ_STAT_OFFSET  = 8'h0C;
   localparam logic [7:0]  IRQ_MASK_OFFSET  = 8'h10;
   localparam logic [7:0]  DISPLAY_OFFSET   = 8'h14;
   localparam logic [7:0]  BEAMS_OFFSET     = 8'h18;
   // control fields
   localparam int          CTRL_LATCH_BIT   = 0;
   localparam int          CTRL_RR_BIT      = 1;
   localparam int          CTRL_LOCKCLR_BIT = 2;
   localparam int          CTRL_TEACH_BIT   = 3;
   localparam logic [31:0] CTRL_RESET_VAL   = 32'h0000_0000;
   localparam logic [4:0]  IRQ_MASK_RESET   = 5'h00;
   // interrupt events
   localparam int          IRQ_TRIP_BIT     = 0;
   localparam int          IRQ_CLEAR_BIT    = 1;
   localparam int          IRQ_LOCK_BIT     = 2;
   localparam int          IRQ_RESET_BIT    = 3;
   localparam int          IRQ_SYNC_BIT     = 4;
   // display codes (12-bit: 3 digits of 4 bits)
   localparam logic [11:0] CODE_MISALIGN    = 12'hC01;
   localparam logic [11:0] CODE_SCAN_BASE   = 12'h500;
   // timing
   localparam int          CLK_MHZ          = 250;
   localparam int          SELFTEST_MS      = 500;
   localparam int          FLASH_MS         = 250;
   localparam int          RESET_MIN_MS     = 250;
   localparam int          RESET_MAX_MS     = 2000;
   localparam longint      SELFTEST_CYC     = longint'(SELFTEST_MS) * CLK_MHZ * 1000;
   localparam longint      FLASH_CYC        = longint'(FLASH_MS) * CLK_MHZ * 1000;
   localparam longint      RESET_MIN_CYC    = longint'(RESET_MIN_MS) * CLK_MHZ * 1000;
   localparam longint      RESET_MAX_CYC    = longint'(RESET_MAX_MS) * CLK_MHZ * 1000;
   // indicator colours
   typedef enum logic [1:0] {LED_OFF, LED_GREEN, LED_RED, LED_YELLOW} led_t;
endpackage : beam_eval_pkg

// >>> test/beam_eval_monitor.sv
module beam_eval_monitor
   import beam_eval_pkg::*;
#(
   parameter int NBEAMS = 16,
   parameter int NZONES = 8
) (
   input wire logic                clk_sys,
   input wire logic                resetn,
   input wire logic [NBEAMS-1:0]   beam_blocked,
   input wire logic                test_input_open,
   input wire logic                safety_switching_output,
   input wire beam_eval_pkg::led_t status_led,
   input wire beam_eval_pkg::led_t emitter_status_led,
   input wire beam_eval_pkg::led_t zone_led [NZONES],
   input wire logic [11:0]         display
);
   timeunit 1ns;
   timeprecision 100ps;
   // =====================================
   // settle counter
   // =====================================
   logic [5:0] up_q;
   // saturates past self-test and syncing
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         up_q <= 6'h00;
      end else if (up_q != 6'h3F) begin
         up_q <= up_q + 6'h01;
      end
   end
   wire ready = (up_q == 6'h3F);
   // =====================================
   // properties
   // =====================================
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // six samples cover sync and output flops
   sequence s_sync;
      (ready && beam_blocked[0] && !test_input_open) [*6];
   endsequence
   sequence s_test;
      (ready && test_input_open) [*6];
   endsequence
   sequence s_norm;
      (ready && !test_input_open) [*6];
   endsequence
   AST_SYNC_ZONE_ONE: assert property (s_sync |-> zone_led[0] == LED_RED)
      else $error("zone one not red on sync block");
   AST_SYNC_OTHERS_OFF: assert property (s_sync |-> zone_led[1] == LED_OFF && zone_led[NZONES-1] == LED_OFF)
      else $error("zones lit on sync block");
   AST_SYNC_STOPS: assert property (s_sync |-> !safety_switching_output)
      else $error("outputs on with sync beam blocked");
   AST_RUN_STATUS: assert property ((ready && safety_switching_output) [*3] |-> status_led != LED_RED)
      else $error("status red while outputs on");
   AST_STOP_STATUS: assert property ((ready && !safety_switching_output) [*3] |-> status_led != LED_GREEN)
      else $error("status green while outputs off");
   AST_EMIT_GREEN: assert property (s_norm |-> emitter_status_led == LED_GREEN)
      else $error("emitter status not steady green");
   AST_TEST_FLASH: assert property (s_test |-> ##[1:9] ($changed(emitter_status_led) || !test_input_open))
      else $error("emitter status not flashing");
   AST_TEST_DISPLAY: assert property (s_test |-> display == 12'(NBEAMS - 1))
      else $error("test mode display wrong");
   AST_SELFTEST: assert property ($rose(resetn) |-> ##[3:8] display == 12'hFFF)
      else $error("no self-test pattern");
endmodule : beam_eval_monitor

bind beam_eval beam_eval_monitor #(.NBEAMS(NBEAMS), .NZONES(NZONES)) i_beam_eval_monitor (
   .clk_sys(clk_sys), .resetn(resetn), .beam_blocked(beam_blocked), .test_input_open(test_input_open),
   .safety_switching_output(safety_switching_output), .status_led(status_led),
   .emitter_status_led(emitter_status_led), .zone_led(zone_led), .display(display));

// >>> test/beam_eval_tb.sv
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
   $display("Error t=%0t got %0h exp %0h", $time, (g), (e)); end end
module beam_eval_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import beam_eval_pkg::*;
   // =====================================
   // signals
   // =====================================
   logic        clk_sys = 1'b0;
   logic        resetn = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  hsize = 3'b010;
   logic        hwrite = 1'b0, hsel = 1'b0, hready, hreadyout, hresp;
   logic [7:0]  obs = '0, beam_blocked, press_len = 8'h0A;
   logic        test_req = 1'b0, press_go = 1'b0, test_input_open, reset_switch;
   logic        safety_switching_output, reset_led, irq;
   led_t        status_led, emitter_status_led;
   led_t        zone_led [8];
   logic [11:0] display;
   logic [3:0]  m;
   int          n_fail = 0;
   int          cmp_count = 0;
   assign hready = hreadyout;
   // 2 ns half period: 250 MHz
   always #2 clk_sys = ~clk_sys;
   beam_eval #(.NBEAMS(8), .SELFTEST_N(20), .FLASH_N(4), .RESET_MIN_N(5), .RESET_MAX_N(40)) i_beam_eval (
      .clk_sys(clk_sys), .resetn(resetn), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hsel(hsel), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .beam_blocked(beam_blocked), .reset_switch(reset_switch), .test_input_open(test_input_open),
      .safety_switching_output(safety_switching_output), .status_led(status_led),
      .emitter_status_led(emitter_status_led), .reset_led(reset_led), .zone_led(zone_led),
      .display(display), .irq(irq));
   emitter_model i_emitter_model (
      .clk_sys(clk_sys), .obstruct(obs), .test_req(test_req), .press_go(press_go), .press_len(press_len),
      .beam_blocked(beam_blocked), .test_input_open(test_input_open), .reset_switch(reset_switch));
   // =====================================
   // helpers
   // =====================================
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   // one word; waits on hready in both phases
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      hwrite <= wr;
      htrans <= 2'b10;
      @(posedge clk_sys);
      while (hready !== 1'b1) @(posedge clk_sys);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge clk_sys);
      while (hready !== 1'b1) @(posedge clk_sys);
      rd = hrdata;
   endtask : bus
   // colours shown over n cycles: steady or flashing
   task automatic seen(input int sel, input int n);
      m = 4'h0;
      repeat (n) begin
         @(posedge clk_sys);
         if (sel == 0) m[status_led] = 1'b1;
         else if (sel == 1) m[emitter_status_led] = 1'b1;
         else m[{1'b0, reset_led}] = 1'b1;
      end
   endtask : seen
   task automatic zones(input logic [7:0] red_m, input led_t oth);
      for (int i = 0; i < 8; i++) `CHK(zone_led[i], red_m[i] ? LED_RED : oth)
   endtask : zones
   task automatic press(input logic [7:0] len);
      press_len <= len;
      press_go  <= 1'b1;
      @(posedge clk_sys);
      press_go  <= 1'b0;
      cyc(len + 12);
   endtask : press
   // =====================================
   // scenarios
   // =====================================
   task automatic t_power();
      cyc(6);
      `CHK(display, 12'hFFF)
      cyc(40);
      `CHK(display, 12'h501)
      `CHK(status_led, LED_GREEN)
      `CHK(reset_led, 1'b1)
      zones(8'h00, LED_GREEN);
      `CHK(hresp, 1'b0)
      bus(0, CTRL_OFFSET, 0);
      `CHK(rd, CTRL_RESET_VAL)
      bus(0, STATUS_OFFSET, 0);
      `CHK(rd[5:0], 6'h21)
      bus(0, 8'h40, 0);
      `CHK(rd, 32'h0000_0000)
      bus(0, IRQ_MASK_OFFSET, 0);
      `CHK(rd[4:0], IRQ_MASK_RESET)
   endtask : t_power
   task automatic t_block();
      bus(1, IRQ_STAT_OFFSET, 32'h1F);
      bus(1, IRQ_MASK_OFFSET, 32'h01);
      obs <= 8'h0C;
      cyc(8);
      `CHK(safety_switching_output, 1'b0)
      `CHK(status_led, LED_RED)
      `CHK(reset_led, 1'b1)
      `CHK(display, 12'h002)
      zones(8'h0C, LED_GREEN);
      `CHK(irq, 1'b1)
      obs <= 8'h04;
      cyc(8);
      `CHK(display, 12'h001)
      zones(8'h04, LED_GREEN);
      bus(1, IRQ_STAT_OFFSET, 32'h01);
      cyc(1);
      `CHK(irq, 1'b0)
      bus(1, IRQ_MASK_OFFSET, 32'h02);
      obs <= 8'h00;
      cyc(8);
      `CHK(safety_switching_output, 1'b1)
      `CHK(irq, 1'b1)
      bus(1, IRQ_STAT_OFFSET, 32'h1F);
      bus(1, IRQ_MASK_OFFSET, 32'h00);
      cyc(1);
      `CHK(irq, 1'b0)
   endtask : t_block
   task automatic t_sync();
      obs <= 8'h01;
      cyc(8);
      zones(8'h01, LED_OFF);
      `CHK(status_led, LED_RED)
      `CHK(display, CODE_MISALIGN)
      obs <= 8'h00;
      cyc(8);
   endtask : t_sync
   task automatic t_rr();
      bus(1, CTRL_OFFSET, 32'h2);
      seen(0, 16);
      `CHK(m, 4'b0011)
      obs <= 8'h18;
      cyc(8);
      `CHK(safety_switching_output, 1'b1)
      obs <= 8'h38;
      cyc(8);
      `CHK(safety_switching_output, 1'b0)
      obs <= 8'h03;
      cyc(8);
      `CHK(safety_switching_output, 1'b0)
      obs <= 8'h00;
      bus(1, CTRL_OFFSET, 32'h0);
      cyc(8);
   endtask : t_rr
   task automatic t_test();
      test_req <= 1'b1;
      cyc(8);
      seen(1, 16);
      `CHK(m, 4'b0011)
      `CHK(display, 12'h007)
      zones(8'hFF, LED_RED);
      test_req <= 1'b0;
      cyc(8);
      seen(1, 16);
      `CHK(m, 4'b0010)
   endtask : t_test
   task automatic t_latch();
      bus(1, CTRL_OFFSET, 32'h1);
      obs <= 8'h40;
      cyc(8);
      obs <= 8'h00;
      cyc(8);
      `CHK(safety_switching_output, 1'b0)
      `CHK(status_led, LED_RED)
      zones(8'h00, LED_GREEN);
      seen(2, 40);
      `CHK(m, 4'b0011)
      press(8'h02);
      `CHK(safety_switching_output, 1'b0)
      press(8'h3C);
      `CHK(safety_switching_output, 1'b0)
      press(8'h0A);
      `CHK(safety_switching_output, 1'b1)
      bus(1, CTRL_OFFSET, 32'h0);
   endtask : t_latch
   task automatic t_blank();
      bus(1, BLANK_OFFSET, 32'h05);
      bus(0, BLANK_OFFSET, 0);
      `CHK(rd, 32'h0000_0000)
      obs <= 8'h24;
      bus(1, CTRL_OFFSET, 32'h8);
      cyc(8);
      bus(1, CTRL_OFFSET, 32'h0);
      cyc(8);
      bus(0, BLANK_OFFSET, 0);
      `CHK(rd, 32'h0000_0024)
      press(8'h0A);
      `CHK(safety_switching_output, 1'b1)
      obs <= 8'h20;
      cyc(8);
      `CHK(safety_switching_output, 1'b0)
      `CHK(reset_led, 1'b0)
      zones(8'h00, LED_OFF);
      seen(0, 40);
      `CHK(m, 4'b0101)
      bus(0, STATUS_OFFSET, 0);
      `CHK(rd[3:0], 4'h4)
      obs <= 8'h00;
      bus(1, BLANK_OFFSET, 32'h0);
      bus(1, CTRL_OFFSET, 32'h4);
      cyc(20);
      `CHK(safety_switching_output, 1'b1)
   endtask : t_blank
   // =====================================
   // sequence and verdict
   // =====================================
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up
   initial begin
      cyc(6);
      resetn <= 1'b1;
      t_power();
      t_block();
      t_sync();
      t_rr();
      t_test();
      t_latch();
      t_blank();
      wrap_up();
   end
   // the run needs about 500 cycles; 40x that is a hang
   initial begin
      cyc(20000);
      n_fail++;
      wrap_up();
   end
endmodule : beam_eval_tb

// >>> test/emitter_model.sv
module emitter_model #(
   parameter int NBEAMS = 8
) (
   input  wire logic              clk_sys,
   input  wire logic [NBEAMS-1:0] obstruct,
   input  wire logic              test_req,
   input  wire logic              press_go,
   input  wire logic [7:0]        press_len,
   output logic      [NBEAMS-1:0] beam_blocked,
   output logic                   test_input_open,
   output logic                   reset_switch
);
   timeunit 1ns;
   timeprecision 100ps;
   // =====================================
   // emitter and operator
   // =====================================
   logic [7:0] hold_q = 8'h00;
   // scene applied one cycle after the bench commands it
   always @(posedge clk_sys) begin
      beam_blocked    <= obstruct;
      test_input_open <= test_req;
   end
   // closed for press_len cycles, then opened
   always @(posedge clk_sys) begin
      if (press_go) begin
         hold_q <= press_len;
      end else if (hold_q != 8'h00) begin
         hold_q <= hold_q - 8'h01;
      end
   end
   assign reset_switch = (hold_q != 8'h00);
endmodule : emitter_model
